//--- canf_pkg.sv
// Package with register map, field layout and mode codes of the CAN filter and interrupt block
// What this block does
// - Two-filter mode: each 32-bit bank compares full identifier; bank0 hit 0, bank1 hit 1
// - Four-filter mode: each 16-bit half-bank matches; hits 0-1 bank0, 2-3 bank1
// - Eight-filter mode: each byte matches first 8 identifier bits; hits 0-7
// - Closed mode never copies a newly received frame to foreground nor sets receive-full by acceptance
// - Pattern registers hold wanted identifier bits; don't-care bits skip comparison
// - Acceptance sets receive-full and loads three-bit hit code
// - Several matches report the lowest-numbered filter
// - Acceptance raises receive interrupt when its enable is set
// - Four vectors fed by eleven sources, each with own mask bit
// - Transmit interrupt requested while any enabled empty flag of three buffers set
// - Receive-full set right after end-of-frame of frame loaded to foreground
// - Wake flag set on receive-line activity while in sleep state
// - Overrun set when accepted frame arrives with both buffers full
// - Warning flags set when receive or transmit error counter reaches 96
// - Passive flags set when respective error counter exceeds 127
// - Bus-off flag set when transmit error counter exceeds 255
// - Sources map to wake, error, receive, transmit vectors; global mask gates all
// - Each request stays asserted while any enabled flag is set
// - Writing one clears a flag, writing zero leaves it
// - A write-one clear is void while the causing condition persists
// - Copy to foreground only while receive-full is clear, then set it
// - Own frames are not copied or interrupting, except in loop-back
package canf_pkg;
  // Register offsets (word index on the plain port)
  localparam logic [4:0] ADDR_PATTERN_0 = 5'h00; // Eight pattern bytes 0x00..0x07
  localparam logic [4:0] ADDR_DONTCARE_0 = 5'h08; // Eight don't-care bytes 0x08..0x0f
  localparam logic [4:0] ADDR_FILTER_CTRL = 5'h10;
  localparam logic [4:0] ADDR_RX_FLAG = 5'h11;
  localparam logic [4:0] ADDR_RX_IRQ_EN = 5'h12;
  localparam logic [4:0] ADDR_TX_FLAG = 5'h13;
  localparam logic [4:0] ADDR_TX_IRQ_EN = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h15;
  // Filter control fields
  localparam int MODE_LSB = 4;
  localparam int HIT_LSB = 0;
  localparam logic [7:0] FILTER_CTRL_RESET = 8'h00;
  // Receive flag / enable bit positions
  localparam int BIT_WAKE = 7;
  localparam int BIT_RX_WARN = 6;
  localparam int BIT_TX_WARN = 5;
  localparam int BIT_RX_PASS = 4;
  localparam int BIT_TX_PASS = 3;
  localparam int BIT_BUS_OFF = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_FULL = 0;
  localparam logic [7:0] ERROR_BITS = 8'h7e;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [2:0] TX_EMPTY_RESET = 3'h7;
  // Error counter thresholds
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
  // Filter modes
  typedef enum logic [1:0] {
    MODE_TWO = 2'h0,
    MODE_FOUR = 2'h1,
    MODE_EIGHT = 2'h2,
    MODE_CLOSED = 2'h3
  } filter_mode_t;
endpackage

//--- canf_match.sv
// Identifier comparator for both banks in all filter modes with lowest-hit priority
`timescale 1ns/1ps
module canf_match
  import canf_pkg::*;
(
  // Programming
  input wire logic [63:0] pattern,
  input wire logic [63:0] dont_care,
  input wire logic [1:0] mode,
  // Frame identifier as four bytes in order, byte 0 first
  input wire logic [31:0] frame_id,
  // Result
  output logic hit,
  output logic [2:0] hit_code
);
  logic [7:0] byte_ok;
  logic [7:0] filt;

  // Pattern byte p sits in bits (7-p)*8 +: 8; every filter starts at the first identifier byte
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      logic [7:0] cmp_id;
      // Frame byte this pattern byte faces in the current mode
      always_comb begin
        cmp_id = frame_id[31:24];
        unique case (filter_mode_t'(mode))
          MODE_TWO: cmp_id = frame_id[31 - 8 * ((7 - g) % 4) -: 8];
          MODE_FOUR: cmp_id = frame_id[31 - 8 * ((7 - g) % 2) -: 8];
          MODE_EIGHT, MODE_CLOSED: cmp_id = frame_id[31:24];
        endcase
      end
      // Per bit equal or ignored; a mask one means don't care
      assign byte_ok[g] = &(dont_care[g*8 +: 8] | ~(pattern[g*8 +: 8] ^ cmp_id));
    end
  endgenerate

  // Bank zero is pattern bytes 0..3, found in byte_ok[7:4]
  always_comb begin
    filt = 8'h00;
    unique case (filter_mode_t'(mode))
      MODE_TWO: begin
        filt[0] = &byte_ok[7:4];
        filt[1] = &byte_ok[3:0];
      end
      MODE_FOUR: begin
        filt[0] = byte_ok[7] & byte_ok[6];
        filt[1] = byte_ok[5] & byte_ok[4];
        filt[2] = byte_ok[3] & byte_ok[2];
        filt[3] = byte_ok[1] & byte_ok[0];
      end
      MODE_EIGHT: begin
        filt = {byte_ok[0], byte_ok[1], byte_ok[2], byte_ok[3],
                byte_ok[4], byte_ok[5], byte_ok[6], byte_ok[7]};
      end
      MODE_CLOSED: filt = 8'h00;
    endcase
  end

  // Lowest numbered filter wins
  always_comb begin
    hit_code = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (filt[i]) begin
        hit_code = 3'(i);
      end
    end
  end
  assign hit = |filt;
endmodule // canf_match

//--- canf_irq.sv
// Interrupt vector gating: sources times local masks, then the global mask
`timescale 1ns/1ps
module canf_irq
  import canf_pkg::*;
(
  // Flags and enables
  input wire logic [7:0] rx_flag_reg,
  input wire logic [7:0] rx_irq_en,
  input wire logic [2:0] tx_flag_reg,
  input wire logic [2:0] tx_irq_en,
  input wire logic global_irq_mask,
  // Vectors
  output logic irq_wake,
  output logic irq_error,
  output logic irq_rx,
  output logic irq_tx
);
  logic [7:0] rx_act;
  assign rx_act = rx_flag_reg & rx_irq_en;
  // Level requests, held while any enabled flag stays set
  assign irq_wake = global_irq_mask & rx_act[BIT_WAKE];
  assign irq_error = global_irq_mask & (|(rx_act & ERROR_BITS));
  assign irq_rx = global_irq_mask & rx_act[BIT_RX_FULL];
  assign irq_tx = global_irq_mask & (|(tx_flag_reg & tx_irq_en));
endmodule // canf_irq

//--- canf_top.sv
// CAN identifier acceptance filter with receive buffering flags and interrupt sources
`timescale 1ns/1ps
module canf_top
  import canf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Receive engine: frame in background buffer at end of frame
  input wire logic frame_done,
  input wire logic [31:0] frame_id,
  input wire logic frame_own,
  input wire logic loop_back,
  // Transmit engine
  input wire logic [2:0] tx_sent,
  // Protocol state
  input wire logic [8:0] rx_err_count,
  input wire logic [8:0] tx_err_count,
  input wire logic sleep_state,
  input wire logic rx_line,
  input wire logic global_irq_mask,
  // Outputs
  output logic copy_to_fore,
  output logic irq_wake,
  output logic irq_error,
  output logic irq_rx,
  output logic irq_tx
);
  typedef struct packed {
    logic [63:0] pattern;
    logic [63:0] dont_care;
    logic [1:0] mode;
    logic [2:0] hit_code;
    logic [7:0] rx_flag;
    logic [7:0] rx_en;
    logic [2:0] tx_flag;
    logic [2:0] tx_en;
    logic back_full;
    logic [2:0] back_code;
    logic copy;
    logic [7:0] rdata;
    logic [2:0] line_sync;
  } state_t;

  state_t r;
  state_t next_r;
  logic hit;
  logic [2:0] hit_code;
  logic [7:0] cond;
  logic line_act;

  canf_match u_match (
    .pattern(r.pattern),
    .dont_care(r.dont_care),
    .mode(r.mode),
    .frame_id(frame_id),
    .hit(hit),
    .hit_code(hit_code)
  );

  canf_irq u_irq (
    .rx_flag_reg(r.rx_flag),
    .rx_irq_en(r.rx_en),
    .tx_flag_reg(r.tx_flag),
    .tx_irq_en(r.tx_en),
    .global_irq_mask(global_irq_mask),
    .irq_wake(irq_wake),
    .irq_error(irq_error),
    .irq_rx(irq_rx),
    .irq_tx(irq_tx)
  );

  // Receive line is asynchronous; a low level counts once stages two and three agree
  assign line_act = (r.line_sync[1] == r.line_sync[2]) & ~r.line_sync[1];

  // Live conditions of the error and wake flags; while one persists its flag resists clearing
  always_comb begin
    cond = 8'h00;
    cond[BIT_RX_WARN] = rx_err_count >= WARN_LIMIT;
    cond[BIT_TX_WARN] = tx_err_count >= WARN_LIMIT;
    cond[BIT_RX_PASS] = rx_err_count > PASSIVE_LIMIT;
    cond[BIT_TX_PASS] = tx_err_count > PASSIVE_LIMIT;
    cond[BIT_BUS_OFF] = tx_err_count > BUS_OFF_LIMIT;
    cond[BIT_WAKE] = sleep_state & line_act;
  end

  // Whole next state
  always_comb begin
    logic accept;
    logic [7:0] rx_set;
    logic [7:0] rx_clr;
    logic [2:0] tx_clr;
    logic forward;
    accept = 1'b0;
    forward = 1'b0;
    rx_set = 8'h00;
    rx_clr = 8'h00;
    tx_clr = 3'h0;
    next_r = r;
    next_r.copy = 1'b0;
    next_r.rdata = 8'h00;
    next_r.line_sync = {r.line_sync[1:0], rx_line};
    rx_set = cond;

    // Frame handling: own frames stay in the background unless looped back
    accept = frame_done & hit & (~frame_own | loop_back);
    // Held frame moves forward first, carrying its own hit code, so older data is never overtaken
    forward = r.back_full & ~r.rx_flag[BIT_RX_FULL] & ~sleep_state;
    if (forward) begin
      next_r.back_full = 1'b0;
      next_r.copy = 1'b1;
      next_r.hit_code = r.back_code;
      rx_set[BIT_RX_FULL] = 1'b1;
    end
    if (accept) begin
      if (!r.rx_flag[BIT_RX_FULL] && !r.back_full) begin
        rx_set[BIT_RX_FULL] = 1'b1;
        next_r.copy = 1'b1;
        next_r.hit_code = hit_code;
      end else if (r.back_full && !forward) begin
        rx_set[BIT_OVERRUN] = 1'b1;
      end else begin
        // Background slot is free, or is being freed by the forward move this cycle
        next_r.back_full = 1'b1;
        next_r.back_code = hit_code;
      end
    end

    // Register writes
    if (reg_write) begin
      if (reg_addr < ADDR_DONTCARE_0) begin
        next_r.pattern[(7 - reg_addr[2:0]) * 8 +: 8] = reg_wdata;
      end else if (reg_addr < ADDR_FILTER_CTRL) begin
        next_r.dont_care[(7 - reg_addr[2:0]) * 8 +: 8] = reg_wdata;
      end else begin
        unique case (reg_addr)
          ADDR_FILTER_CTRL: next_r.mode = reg_wdata[MODE_LSB +: 2];
          ADDR_RX_FLAG: rx_clr = reg_wdata;
          ADDR_RX_IRQ_EN: next_r.rx_en = reg_wdata;
          ADDR_TX_FLAG: tx_clr = reg_wdata[2:0]; // Software schedules the buffer
          ADDR_TX_IRQ_EN: next_r.tx_en = reg_wdata[2:0];
          default: ;
        endcase
      end
    end

    // Set wins over clear, and a clear is void while the cause remains
    next_r.rx_flag = (r.rx_flag & ~(rx_clr & ~cond)) | rx_set;
    next_r.tx_flag = (r.tx_flag & ~tx_clr) | tx_sent;

    // Register reads, data in the following cycle
    if (reg_read) begin
      if (reg_addr < ADDR_DONTCARE_0) begin
        next_r.rdata = r.pattern[(7 - reg_addr[2:0]) * 8 +: 8];
      end else if (reg_addr < ADDR_FILTER_CTRL) begin
        next_r.rdata = r.dont_care[(7 - reg_addr[2:0]) * 8 +: 8];
      end else begin
        unique case (reg_addr)
          ADDR_FILTER_CTRL: next_r.rdata = {2'h0, r.mode, 1'b0, r.hit_code};
          ADDR_RX_FLAG: next_r.rdata = r.rx_flag;
          ADDR_RX_IRQ_EN: next_r.rdata = r.rx_en;
          ADDR_TX_FLAG: next_r.rdata = {5'h00, r.tx_flag};
          ADDR_TX_IRQ_EN: next_r.rdata = {5'h00, r.tx_en};
          ADDR_STATUS: next_r.rdata = {6'h00, sleep_state, r.back_full};
          default: next_r.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r <= '0;
      r.tx_flag <= TX_EMPTY_RESET;
      r.line_sync <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign copy_to_fore = r.copy;

  // Closed mode never sets receive-full by acceptance
  AST_CLOSED_NO_FULL: assert property (@(posedge clk_sys) disable iff (reset)
    (r.mode == MODE_CLOSED && frame_done && !r.back_full && !r.rx_flag[BIT_RX_FULL])
      |=> !r.rx_flag[BIT_RX_FULL])
    else $error("closed filter set receive-full");

  sequence s_accept_free;
    frame_done && hit && !frame_own && !r.rx_flag[BIT_RX_FULL] && !r.back_full;
  endsequence
  AST_ACCEPT_SETS_FULL: assert property (@(posedge clk_sys) disable iff (reset)
    s_accept_free |=> (r.rx_flag[BIT_RX_FULL] && r.copy && r.hit_code == $past(hit_code)))
    else $error("acceptance did not load foreground");

  AST_OWN_FRAME_IGNORED: assert property (@(posedge clk_sys) disable iff (reset)
    (frame_done && frame_own && !loop_back && !r.back_full && !r.rx_flag[BIT_RX_FULL])
      |=> !r.rx_flag[BIT_RX_FULL])
    else $error("own frame reached foreground");

  AST_OVERRUN: assert property (@(posedge clk_sys) disable iff (reset)
    (frame_done && hit && !frame_own && r.back_full && r.rx_flag[BIT_RX_FULL]) |=> r.rx_flag[BIT_OVERRUN])
    else $error("overrun not flagged");

  AST_WARN_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
    (rx_err_count >= WARN_LIMIT) |=> r.rx_flag[BIT_RX_WARN])
    else $error("warning flag cleared while condition holds");

  AST_BUS_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    (tx_err_count > BUS_OFF_LIMIT) |=> r.rx_flag[BIT_BUS_OFF])
    else $error("bus-off flag missing");

  AST_W1C: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && reg_addr == ADDR_RX_FLAG && reg_wdata[BIT_OVERRUN] == 1'b0 && r.rx_flag[BIT_OVERRUN])
      |=> r.rx_flag[BIT_OVERRUN])
    else $error("writing zero cleared a flag");

  AST_TX_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
    (global_irq_mask && |(r.tx_flag & r.tx_en)) |-> irq_tx)
    else $error("transmit request missing");

  AST_RX_READ: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && reg_addr == ADDR_RX_FLAG) |=> reg_rdata == $past(r.rx_flag))
    else $error("flag read data wrong");
endmodule // canf_top

//--- can_node_model.sv
// Far-side node model that hands finished frames to the filter block
`timescale 1ns/1ps
module can_node_model (
  // Clock
  input wire logic clk_sys,
  // Frame handed over at end of frame
  output logic frame_done,
  output logic [31:0] frame_id,
  output logic frame_own
);
  // Idle values at time zero
  initial begin
    frame_done = 1'b0;
    frame_id = 32'h0;
    frame_own = 1'b0;
  end

  // One-cycle end-of-frame pulse; the identifier is inverted afterwards so a stale id differs from the delivered one in every bit
  task automatic deliver(input logic [31:0] id, input logic own);
    @(posedge clk_sys);
    frame_done <= 1'b1;
    frame_id <= id;
    frame_own <= own;
    @(posedge clk_sys);
    frame_done <= 1'b0;
    frame_id <= ~id;
    frame_own <= ~own;
  endtask
endmodule // can_node_model

//--- tb.sv
// Self-checking bench for the CAN filter and interrupt block
`timescale 1ns/1ps
module tb;
  import canf_pkg::*;
  // Design inputs and outputs
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic loop_back = 1'b0;
  logic [2:0] tx_sent = 3'h0;
  logic [8:0] rx_err_count = 9'h000;
  logic [8:0] tx_err_count = 9'h000;
  logic sleep_state = 1'b0;
  logic rx_line = 1'b1;
  logic global_irq_mask = 1'b1;
  logic [7:0] reg_rdata;
  logic frame_done, frame_own, copy_to_fore, irq_wake, irq_error, irq_rx, irq_tx;
  logic [31:0] frame_id;
  // Bench state and error-counter cases
  int err_count = 0;
  int n_checks = 0;
  int w;
  logic [7:0] v;
  logic [7:0] pat [8];
  logic [7:0] dcb [8];
  logic [31:0] id;
  logic [3:0] e;
  logic [1:0] m;
  logic [8:0] rc [6] = '{9'h060, 9'h000, 9'h080, 9'h000, 9'h000, 9'h05f};
  logic [8:0] tc [6] = '{9'h000, 9'h060, 9'h000, 9'h080, 9'h100, 9'h07f};
  logic [7:0] em [6] = '{8'h40, 8'h20, 8'h50, 8'h28, 8'h2c, 8'h20};

  always #2.5 clk_sys = ~clk_sys;

  can_node_model i_can_node_model (.clk_sys(clk_sys), .frame_done(frame_done), .frame_id(frame_id),
    .frame_own(frame_own));
  canf_top i_canf_top (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .frame_done(frame_done),
    .frame_id(frame_id), .frame_own(frame_own), .loop_back(loop_back), .tx_sent(tx_sent),
    .rx_err_count(rx_err_count), .tx_err_count(tx_err_count), .sleep_state(sleep_state),
    .rx_line(rx_line), .global_irq_mask(global_irq_mask), .copy_to_fore(copy_to_fore),
    .irq_wake(irq_wake), .irq_error(irq_error), .irq_rx(irq_rx), .irq_tx(irq_tx));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    n_checks++;
    if (g !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic prog(input logic [1:0] md);
    for (int j = 0; j < 8; j++) begin
      wr(ADDR_PATTERN_0 + 5'(j), pat[j]);
      wr(ADDR_DONTCARE_0 + 5'(j), dcb[j]);
    end
    wr(ADDR_FILTER_CTRL, {2'h0, md, 4'h0});
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Expected {hit, code}: filter k owns w bytes compared with the first w id bytes; lowest k wins
  function automatic logic [3:0] exp_hit(input logic [1:0] md, input logic [31:0] fid);
    logic [3:0] r;
    int wd;
    logic ok;
    r = 4'h0;
    wd = (md == MODE_TWO) ? 4 : (md == MODE_FOUR) ? 2 : 1;
    if (md != MODE_CLOSED)
      for (int k = 8 / wd - 1; k >= 0; k--) begin
        ok = 1'b1;
        for (int b = 0; b < wd; b++)
          if (((pat[k*wd+b] ^ fid[31-8*b -: 8]) & ~dcb[k*wd+b]) != 8'h00)
            ok = 1'b0;
        if (ok)
          r = {1'b1, 3'(k)};
      end
    return r;
  endfunction

  initial begin
    void'($urandom(39));
    tick(5);
    reset <= 1'b0;
    rd(ADDR_FILTER_CTRL);
    chk("ctrl", FILTER_CTRL_RESET, v);
    rd(ADDR_TX_FLAG);
    chk("txflags", {5'h0, TX_EMPTY_RESET}, v);
    rd(5'h1f);
    chk("unmapped", 8'h00, v);
    wr(ADDR_RX_IRQ_EN, 8'hff);
    wr(ADDR_TX_IRQ_EN, 8'h07);
    // Random ids against patterns that mostly copy them, so several filters often hit at once
    for (int i = 0; i < 32; i++) begin
      m = 2'(i % 4);
      id = $urandom;
      w = (m == MODE_TWO) ? 4 : (m == MODE_FOUR) ? 2 : 1;
      for (int j = 0; j < 8; j++) begin
        pat[j] = ($urandom % 3 == 0) ? 8'($urandom) : id[31-8*(j%w) -: 8];
        dcb[j] = 8'($urandom & $urandom & $urandom);
      end
      prog(m);
      e = exp_hit(m, id);
      i_can_node_model.deliver(id, 1'b0);
      #1 chk("copy", {7'h0, e[3]}, {7'h0, copy_to_fore});
      chk("irq_rx", {7'h0, e[3]}, {7'h0, irq_rx});
      rd(ADDR_FILTER_CTRL);
      if (e[3])
        chk("hit", {2'h0, m, 1'b0, e[2:0]}, v & 8'h37);
      rd(ADDR_RX_FLAG);
      chk("rxfull", {7'h0, e[3]}, v);
      wr(ADDR_RX_FLAG, 8'h01);
    end
    // Own frames, then fill both buffers and overrun
    for (int j = 0; j < 8; j++)
      dcb[j] = 8'hff;
    prog(MODE_TWO);
    for (int lb = 0; lb < 2; lb++) begin
      @(posedge clk_sys);
      loop_back <= 1'(lb);
      i_can_node_model.deliver($urandom, 1'b1);
      #1 chk("own_copy", 8'(lb), {7'h0, copy_to_fore});
    end
    i_can_node_model.deliver($urandom, 1'b0);
    #1 chk("held", 8'h00, {7'h0, copy_to_fore});
    rd(ADDR_STATUS);
    chk("status_held", 8'h01, v);
    i_can_node_model.deliver($urandom, 1'b0);
    rd(ADDR_RX_FLAG);
    chk("overrun", 8'h03, v);
    wr(ADDR_RX_FLAG, 8'h02);
    rd(ADDR_RX_FLAG);
    chk("w1c_zero", 8'h01, v);
    wr(ADDR_RX_FLAG, 8'h01);
    #1;
    for (w = 0; w < 8 && copy_to_fore !== 1'b1; w++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("refill", 8'h01, {7'h0, copy_to_fore});
    if (w == 8)
      wrap_up();
    wr(ADDR_RX_FLAG, 8'h01);
    // Error counter thresholds, including just below the warning and passive limits
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      rx_err_count <= rc[k];
      tx_err_count <= tc[k];
      global_irq_mask <= (k == 5) ? 1'b1 : 1'($urandom);
      tick(3);
      rd(ADDR_RX_FLAG);
      chk("errflags", em[k], v & ERROR_BITS);
      chk("irq_error", {7'h0, global_irq_mask}, {7'h0, irq_error});
      wr(ADDR_RX_FLAG, ERROR_BITS);
      rd(ADDR_RX_FLAG);
      chk("sticky", em[k], v & ERROR_BITS);
      @(posedge clk_sys);
      rx_err_count <= 9'h000;
      tx_err_count <= 9'h000;
      tick(2);
      wr(ADDR_RX_FLAG, ERROR_BITS);
      rd(ADDR_RX_FLAG);
      chk("cleared", 8'h00, v);
    end
    // Transmit empty flags, one buffer at a time
    for (int n = 0; n < 3; n++) begin
      wr(ADDR_TX_FLAG, 8'h07);
      #1 chk("irq_tx_off", 8'h00, {7'h0, irq_tx});
      @(posedge clk_sys);
      tx_sent <= 3'(1 << n);
      @(posedge clk_sys);
      tx_sent <= 3'h0;
      #1 chk("irq_tx_on", 8'h01, {7'h0, irq_tx});
      rd(ADDR_TX_FLAG);
      chk("txflag", 8'(1 << n), v);
      wr(ADDR_TX_IRQ_EN, 8'(~(1 << n)) & 8'h07);
      #1 chk("irq_tx_mask", 8'h00, {7'h0, irq_tx});
      wr(ADDR_TX_IRQ_EN, 8'h07);
    end
    // Wake-up from line activity during sleep
    @(posedge clk_sys);
    sleep_state <= 1'b1;
    rx_line <= 1'b0;
    tick(6);
    rd(ADDR_RX_FLAG);
    chk("wake", 8'h80, v);
    chk("irq_wake", 8'h01, {7'h0, irq_wake});
    rd(ADDR_STATUS);
    chk("status_sleep", 8'h02, v);
    wr(ADDR_RX_FLAG, 8'h80);
    rd(ADDR_RX_FLAG);
    chk("wake_held", 8'h80, v);
    @(posedge clk_sys);
    sleep_state <= 1'b0;
    rx_line <= 1'b1;
    tick(6);
    wr(ADDR_RX_FLAG, 8'h80);
    rd(ADDR_RX_FLAG);
    chk("wake_clr", 8'h00, v);
    wrap_up();
  end
endmodule // tb
